/* File: sim/fpm_menu_asserts.sv */
// Concurrent assertion checker for the front panel menu controller.
`timescale 1ns/1ps
`default_nettype none
module fpm_menu_asserts
	import fpm_pkg::*;
#(
	parameter int unsigned P_MSG_CYC  = MSG_CYC,
	parameter int unsigned P_IDLE_CYC = IDLE_CYC
) (
	input wire logic                i_clk_sys,
	input wire logic                i_sys_rst,
	input wire logic [NUM_KEYS-1:0] i_key_raw,
	input wire logic [19:0]         i_param_value,
	input wire logic                i_error_active,
	input wire fpm_state_t          o_view,
	input wire fpm_param_t          o_param_sel,
	input wire logic                o_param_save,
	input wire logic [2:0]          o_disp_kind,
	input wire logic [DIGITS-1:0]   o_digit_blank,
	input wire logic [2:0]          o_cursor
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	// ----------------------------------------------------------------
	// Dwell counter of the present view
	// ----------------------------------------------------------------
	fpm_state_t  prev;
	logic [31:0] dwell;
	always_ff @(posedge i_clk_sys) begin
		prev  <= o_view;
		dwell <= (i_sys_rst || o_view != prev) ? 32'h1 : dwell + 32'h1;
	end
	a_name_time: assert property ((o_view == FPM_ST_STATUS && prev == FPM_ST_NAME) |->
		(dwell >= P_MSG_CYC - 2 && dwell <= P_MSG_CYC + 4)) else $error("name phase length");
	a_name_exit: assert property (o_view == FPM_ST_NAME |=> o_view inside {FPM_ST_NAME,
		FPM_ST_STATUS}) else $error("name phase left wrongly");
	a_kind_tracks: assert property (o_view != $past(o_view) |=>
		o_disp_kind == $past(o_view)) else $error("display kind lags");
	a_status_next: assert property (o_view == FPM_ST_STATUS |=> o_view inside {FPM_ST_STATUS,
		FPM_ST_ERROR}) else $error("status view left wrongly");
	a_error_next: assert property (o_view == FPM_ST_ERROR |=> o_view inside {FPM_ST_ERROR,
		FPM_ST_PARAM}) else $error("error view left wrongly");
	a_error_forced: assert property (($rose(i_error_active) && o_view inside {FPM_ST_STATUS,
		FPM_ST_PARAM}) |-> ##[1:3] o_view == FPM_ST_ERROR) else $error("error not forced");
	a_cursor_range: assert property (o_cursor <= CUR_MAX) else $error("cursor out of range");
	a_blink_cursor: assert property ((o_digit_blank & ~(5'h01 << $past(o_cursor))) == 5'h00)
		else $error("wrong digit blanked");
	a_cursor_hold: assert property ($past(i_key_raw, 2) == '0 |-> $stable(o_cursor))
		else $error("cursor moved without key");
	a_edit_open: assert property ((o_view == FPM_ST_PARAM ##1 o_view == FPM_ST_EDIT) |->
		o_param_sel.value == $past(i_param_value)) else $error("opened value wrong");
	a_save_pulse: assert property (o_param_save |-> $past(o_view) == FPM_ST_EDIT &&
		o_view == FPM_ST_MSG ##1 !o_param_save) else $error("save pulse wrong");
	a_msg_time: assert property ((o_view == FPM_ST_PARAM && prev == FPM_ST_MSG) |->
		(dwell >= P_MSG_CYC - 1 && dwell <= P_MSG_CYC + 12)) else $error("message length");
endmodule : fpm_menu_asserts
bind fpm_menu fpm_menu_asserts #(.P_MSG_CYC(P_MSG_CYC), .P_IDLE_CYC(P_IDLE_CYC)) u_chk (
	.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_key_raw(i_key_raw),
	.i_param_value(i_param_value), .i_error_active(i_error_active), .o_view(o_view),
	.o_param_sel(o_param_sel), .o_param_save(o_param_save), .o_disp_kind(o_disp_kind),
	.o_digit_blank(o_digit_blank), .o_cursor(o_cursor));
`default_nettype wire

/* File: sim/fpm_operator.sv */
// Behavioural operator that presses one front panel key at a time.
`timescale 1ns/1ps
`default_nettype none
module fpm_operator
	import fpm_pkg::*;
#(
	parameter int unsigned P_DEB_CYC = DEB_CYC
) (
	input  wire logic                i_clk_sys,
	input  wire logic                i_go,
	input  wire logic [2:0]          i_key,
	output logic      [NUM_KEYS-1:0] o_key_raw,
	output logic                     o_busy
);
	int         n;
	logic [2:0] k;
	initial begin
		o_key_raw = '0;
		o_busy    = 1'b0;
		forever begin
			@(posedge i_clk_sys);
			if (i_go) begin
				#1;
				k      = i_key;
				o_busy = 1'b1;
				// Contacts chatter before settling, so the debouncer must filter it.
				for (n = 0; n < 6; n++) begin
					o_key_raw[k] = ~o_key_raw[k];
					@(posedge i_clk_sys);
					#1;
				end
				// Held well past the debounce time; a held key must act only once.
				o_key_raw[k] = 1'b1;
				repeat (P_DEB_CYC + P_DEB_CYC / 2) @(posedge i_clk_sys);
				#1;
				o_key_raw[k] = 1'b0;
				repeat (P_DEB_CYC + P_DEB_CYC / 2) @(posedge i_clk_sys);
				#1;
				o_busy = 1'b0;
			end
		end
	end
endmodule : fpm_operator
`default_nettype wire

/* File: sim/front_panel_menu_control_tb_top.sv */
// Self-checking testbench of the front panel menu controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
	$display("[ERR] %0t value mismatch", $time); end end
module front_panel_menu_control_tb_top
	import fpm_pkg::*;
;
	localparam int unsigned MSG = 50;
	localparam int unsigned IDLE = 2000;
	localparam int unsigned DEB = 20;
	localparam int unsigned BLINK = 16;
	logic clk = 1'b0, rst, go, err_on, saw_save, seen;
	logic [2:0] key, rcode;
	logic [4:0] sel, osel;
	logic [19:0] sval, ecode, pval, expv, saved;
	logic [NUM_KEYS-1:0] keys;
	fpm_save_res_t res;
	fpm_state_t view, save_view;
	fpm_param_t psel;
	logic save, busy;
	logic [19:0] dbcd;
	logic [2:0] kind, cur;
	logic [DIGITS-1:0] blank;
	int tests_run = 0, miscompares = 0;
	always #4 clk = ~clk;
	fpm_operator #(.P_DEB_CYC(DEB)) u_op (.i_clk_sys(clk), .i_go(go), .i_key(key), .o_key_raw(keys),
		.o_busy(busy));
	fpm_menu #(.P_MSG_CYC(MSG), .P_IDLE_CYC(IDLE), .P_DEB_CYC(DEB), .P_BLINK_CYC(BLINK)) dut (
		.i_clk_sys(clk), .i_sys_rst(rst),
		.i_key_raw(keys), .i_status_sel(sel), .i_status_value(sval), .i_error_active(err_on),
		.i_error_code(ecode), .i_param_value(pval), .i_save_result(res), .o_view(view),
		.o_sel(osel), .o_param_sel(psel), .o_param_save(save), .o_disp_bcd(dbcd),
		.o_disp_kind(kind), .o_digit_blank(blank), .o_cursor(cur));
	// ----------------------------------------------------------------
	// Storage side: answers a save two cycles later with a random code
	// ----------------------------------------------------------------
	always @(posedge clk) if (save === 1'b1) begin
		saw_save  = 1'b1;
		saved     = psel.value;
		save_view = view;
		repeat (2) @(posedge clk);
		#1 res = '{code: 3'($urandom % 8), done: 1'b1};
		rcode     = res.code;
		@(posedge clk);
		#1 res.done = 1'b0;
	end
	function automatic logic [19:0] rand_bcd();
		logic [19:0] v;
		for (int i = 0; i < 5; i++) v[4*i+:4] = 4'($urandom % 10);
		return v;
	endfunction : rand_bcd
	function automatic logic [19:0] step(logic [19:0] v, int c, bit up);
		v[4*c+:4] = up ? (v[4*c+:4] == 4'h9 ? 4'h0 : v[4*c+:4] + 4'h1)
			: (v[4*c+:4] == 4'h0 ? 4'h9 : v[4*c+:4] - 4'h1);
		return v;
	endfunction : step
	task automatic conclude();
		$display("tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude
	task automatic press(int k);
		int t;
		go  = 1'b1;
		key = 3'(k);
		@(posedge clk);
		#1 go = 1'b0;
		@(posedge clk);
		for (t = 0; busy && t < 4 * DEB + 100; t++) @(posedge clk);
		repeat (4) @(posedge clk);
		#1;
		if (busy) begin miscompares++; conclude(); end
	endtask : press
	task automatic wait_view(fpm_state_t v, int lim);
		int t;
		for (t = 0; view !== v && t < lim; t++) @(posedge clk) #1;
		if (view !== v) begin miscompares++; conclude(); end
		repeat (2) @(posedge clk);
		#1;
	endtask : wait_view
	initial begin
		rst = 1'b1; go = 1'b0; key = 3'h0; err_on = 1'b0; res = '0; saw_save = 1'b0;
		void'($urandom(19905));
		sel = 5'($urandom % NUM_SEL); sval = rand_bcd(); ecode = rand_bcd(); pval = rand_bcd();
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		`CHK(view, FPM_ST_NAME)
		repeat (2) @(posedge clk);
		#1;
		`CHK(dbcd, ({15'h0, sel}))
		`CHK(osel, sel)
		wait_view(FPM_ST_STATUS, 2000);
		`CHK(dbcd, sval)
		`CHK(kind, 3'h1)
		press(KEY_UP);
		`CHK(osel, 5'((int'(sel) + 1) % int'(NUM_SEL)))
		press(KEY_MODE);
		`CHK(view, FPM_ST_ERROR)
		`CHK(dbcd, ecode)
		press(KEY_MODE);
		`CHK(view, FPM_ST_PARAM)
		press(KEY_SHIFT);
		`CHK(psel.group, 4'h1)
		press(KEY_UP);
		`CHK(psel.index, 8'h01)
		press(KEY_DOWN);
		press(KEY_DOWN);
		`CHK(psel.index, 8'h63)
		press(KEY_OK);
		`CHK(view, FPM_ST_EDIT)
		`CHK(psel.value, pval)
		press(KEY_UP);
		expv = step(pval, 0, 1'b1);
		`CHK(psel.value, expv)
		press(KEY_SHIFT);
		`CHK(cur, 3'h1)
		seen = 1'b0;
		repeat (2 * BLINK + 4) begin
			@(posedge clk);
			#1 seen = seen | blank[1];
			`CHK(blank & 5'h1D, 5'h00)
		end
		`CHK(seen, 1'b1)
		press(KEY_DOWN);
		expv = step(expv, 1, 1'b0);
		`CHK(psel.value, expv)
		`CHK(dbcd, expv)
		press(KEY_OK);
		`CHK(saw_save, 1'b1)
		`CHK(saved, expv)
		`CHK(save_view, FPM_ST_MSG)
		`CHK(dbcd, ({17'h0, rcode}))
		wait_view(FPM_ST_PARAM, 2 * MSG);
		`CHK(view, FPM_ST_PARAM)
		err_on = 1'b1;
		wait_view(FPM_ST_ERROR, 4);
		`CHK(dbcd, ecode)
		press(KEY_MODE);
		`CHK(view, FPM_ST_PARAM)
		wait_view(FPM_ST_ERROR, IDLE + 2 * DEB);
		`CHK(kind, 3'h2)
		press(KEY_MODE);
		press(KEY_MODE);
		`CHK(view, FPM_ST_STATUS)
		conclude();
	end
endmodule : front_panel_menu_control_tb_top
`default_nettype wire

/* File: src/fpm_key_debounce.sv */
// Key debouncer that emits one pulse per press for each front panel key.
`timescale 1ns/1ps
`default_nettype none
module fpm_key_debounce
	import fpm_pkg::*;
#(
	parameter int unsigned P_DEB_CYC = DEB_CYC
) (
	input  wire logic                i_clk_sys,
	input  wire logic                i_sys_rst,
	input  wire logic [NUM_KEYS-1:0] i_key_raw,
	output logic      [NUM_KEYS-1:0] o_key_press
);

	// --------------------------------------------------------------------
	// Per-key filter
	// --------------------------------------------------------------------
	// A level is accepted only after staying unchanged for the whole
	// debounce time, so contact chatter never yields a second press.
	genvar g;
	generate
		for (g = 0; g < NUM_KEYS; g++) begin : g_key
			logic        stable;
			logic [20:0] cnt;
			always_ff @(posedge i_clk_sys) begin
				if (i_sys_rst) begin
					stable         <= 1'b0;
					cnt            <= 21'h0;
					o_key_press[g] <= 1'b0;
				end else begin
					o_key_press[g] <= 1'b0;
					if (i_key_raw[g] == stable) begin
						cnt <= 21'h0;
					end else if (cnt == 21'(P_DEB_CYC - 1)) begin
						cnt            <= 21'h0;
						stable         <= i_key_raw[g];
						o_key_press[g] <= i_key_raw[g];
					end else begin
						cnt <= cnt + 21'h1;
					end
				end
			end
		end
	endgenerate

endmodule : fpm_key_debounce
`default_nettype wire

/* File: src/fpm_menu.sv */
// Front panel menu controller: view selection, parameter editing and display.
`timescale 1ns/1ps
`default_nettype none
module fpm_menu
	import fpm_pkg::*;
#(
	parameter int unsigned P_MSG_CYC   = MSG_CYC,
	parameter int unsigned P_IDLE_CYC  = IDLE_CYC,
	parameter int unsigned P_DEB_CYC   = DEB_CYC,
	parameter int unsigned P_BLINK_CYC = BLINK_CYC
) (
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_sys_rst,
	input  wire logic [NUM_KEYS-1:0]   i_key_raw,
	input  wire logic [4:0]            i_status_sel,
	input  wire logic [19:0]           i_status_value,
	input  wire logic                  i_error_active,
	input  wire logic [19:0]           i_error_code,
	input  wire logic [19:0]           i_param_value,
	input  wire fpm_save_res_t         i_save_result,
	output fpm_state_t                 o_view,
	output logic [4:0]                 o_sel,
	output fpm_param_t                 o_param_sel,
	output logic                       o_param_save,
	output logic [19:0]                o_disp_bcd,
	output logic [2:0]                 o_disp_kind,
	output logic [DIGITS-1:0]          o_digit_blank,
	output logic [2:0]                 o_cursor
);

	// --------------------------------------------------------------------
	// Keys
	// --------------------------------------------------------------------
	logic [NUM_KEYS-1:0] press;
	fpm_keys_t           k;
	logic                any_key;

	fpm_key_debounce #(.P_DEB_CYC(P_DEB_CYC)) u_deb (
		.i_clk_sys   (i_clk_sys),
		.i_sys_rst   (i_sys_rst),
		.i_key_raw   (i_key_raw),
		.o_key_press (press)
	);

	assign k       = fpm_keys_t'(press);
	assign any_key = |press;

	// --------------------------------------------------------------------
	// State
	// --------------------------------------------------------------------
	fpm_state_t  state;
	fpm_state_t  next_state;
	logic [31:0] tmr;
	logic [31:0] idle;
	logic        err_q;
	logic [19:0] edit;
	logic [2:0]  cur;
	logic [4:0]  sel;
	logic [3:0]  grp;
	logic [7:0]  pidx;
	logic [24:0] blink_cnt;
	logic        blink;
	logic        msg_wait;
	logic [2:0]  msg_code;

	wire logic err_new  = i_error_active && !err_q;
	wire logic idle_out = i_error_active && (idle >= 32'(P_IDLE_CYC - 1));

	always_comb begin
		next_state = state;
		case (state)
			FPM_ST_NAME: begin
				if (tmr >= 32'(P_MSG_CYC - 1)) begin
					next_state = FPM_ST_STATUS;
				end
			end
			FPM_ST_STATUS: begin
				if (k.mode) begin
					next_state = FPM_ST_ERROR;
				end
			end
			FPM_ST_ERROR: begin
				if (k.mode) begin
					next_state = FPM_ST_PARAM;
				end
			end
			FPM_ST_PARAM: begin
				if (k.mode) begin
					next_state = FPM_ST_STATUS;
				end else if (k.ok) begin
					next_state = FPM_ST_EDIT;
				end
			end
			FPM_ST_EDIT: begin
				if (k.ok) begin
					next_state = FPM_ST_MSG;
				end else if (k.mode) begin
					next_state = FPM_ST_STATUS;
				end
			end
			FPM_ST_MSG: begin
				if (!msg_wait && tmr >= 32'(P_MSG_CYC - 1)) begin
					next_state = FPM_ST_PARAM;
				end
			end
			default: next_state = FPM_ST_STATUS;
		endcase
		// An error outranks navigation; the save message is left to finish.
		if ((err_new || idle_out) && state != FPM_ST_NAME && state != FPM_ST_MSG) begin
			next_state = FPM_ST_ERROR;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			state <= FPM_ST_NAME;
			err_q <= 1'b0;
		end else begin
			state <= next_state;
			err_q <= i_error_active;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || next_state != state || msg_wait) begin
			tmr <= 32'h0;
		end else begin
			tmr <= tmr + 32'h1;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || any_key || !i_error_active || state == FPM_ST_ERROR) begin
			idle <= 32'h0;
		end else begin
			idle <= idle + 32'h1;
		end
	end

	// --------------------------------------------------------------------
	// Navigation and editing
	// --------------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			sel <= 5'h0;
		end else if (state == FPM_ST_NAME) begin
			sel <= i_status_sel;
		end else if (state == FPM_ST_STATUS && k.up) begin
			sel <= (sel == NUM_SEL - 5'h1) ? 5'h0 : sel + 5'h1;
		end else if (state == FPM_ST_STATUS && k.down) begin
			sel <= (sel == 5'h0) ? NUM_SEL - 5'h1 : sel - 5'h1;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			grp  <= 4'h0;
			pidx <= 8'h0;
		end else if (state == FPM_ST_PARAM) begin
			if (k.shift) begin
				grp  <= (grp == NUM_GROUPS - 4'h1) ? 4'h0 : grp + 4'h1;
				pidx <= 8'h0;
			end else if (k.up) begin
				pidx <= (pidx == NUM_PARAMS - 8'h1) ? 8'h0 : pidx + 8'h1;
			end else if (k.down) begin
				pidx <= (pidx == 8'h0) ? NUM_PARAMS - 8'h1 : pidx - 8'h1;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			edit <= 20'h0;
			cur  <= 3'h0;
		end else if (state == FPM_ST_PARAM && k.ok) begin
			edit <= i_param_value;
			cur  <= 3'h0;
		end else if (state == FPM_ST_EDIT) begin
			if (k.shift) begin
				cur <= (cur == CUR_MAX) ? 3'h0 : cur + 3'h1;
			end else if (k.up) begin
				edit[cur*4 +: 4] <= (edit[cur*4 +: 4] >= DIGIT_MAX) ? 4'h0
				                   : edit[cur*4 +: 4] + 4'h1;
			end else if (k.down) begin
				edit[cur*4 +: 4] <= (edit[cur*4 +: 4] == 4'h0) ? DIGIT_MAX
				                   : edit[cur*4 +: 4] - 4'h1;
			end
		end
	end

	// The message timer starts only once storage has answered, so a slow
	// store still gets its full second of feedback on the display.
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_param_save <= 1'b0;
			msg_wait     <= 1'b0;
			msg_code     <= 3'h0;
		end else begin
			o_param_save <= (state == FPM_ST_EDIT) && k.ok;
			if (state == FPM_ST_EDIT && k.ok) begin
				msg_wait <= 1'b1;
			end else if (msg_wait && i_save_result.done) begin
				msg_wait <= 1'b0;
				msg_code <= i_save_result.code;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || state != FPM_ST_EDIT) begin
			blink_cnt <= 25'h0;
			blink     <= 1'b0;
		end else if (blink_cnt == 25'(P_BLINK_CYC - 1)) begin
			blink_cnt <= 25'h0;
			blink     <= !blink;
		end else begin
			blink_cnt <= blink_cnt + 25'h1;
		end
	end

	// --------------------------------------------------------------------
	// Display
	// --------------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_disp_bcd  <= 20'h0;
			o_disp_kind <= 3'h0;
		end else begin
			o_disp_kind <= 3'(state);
			case (state)
				FPM_ST_NAME:   o_disp_bcd <= {15'h0, sel};
				FPM_ST_STATUS: o_disp_bcd <= i_status_value;
				FPM_ST_ERROR:  o_disp_bcd <= i_error_code;
				FPM_ST_PARAM:  o_disp_bcd <= {8'h0, grp, pidx};
				FPM_ST_EDIT:   o_disp_bcd <= edit;
				FPM_ST_MSG:    o_disp_bcd <= {17'h0, msg_code};
				default:       o_disp_bcd <= 20'h0;
			endcase
		end
	end

	genvar d;
	generate
		for (d = 0; d < DIGITS; d++) begin : g_blank
			always_ff @(posedge i_clk_sys) begin
				if (i_sys_rst) begin
					o_digit_blank[d] <= 1'b0;
				end else begin
					o_digit_blank[d] <= (state == FPM_ST_EDIT) && (cur == 3'(d)) && blink;
				end
			end
		end
	endgenerate

	assign o_view      = state;
	assign o_sel       = sel;
	assign o_cursor    = cur;
	assign o_param_sel = '{group: grp, index: pidx, value: edit};

endmodule : fpm_menu
`default_nettype wire

/* File: src/fpm_pkg.sv */
// Package of constants and types for the front panel menu control.
// Behaviour
// - At power-on show selected status function name one second, then its live value.
// - Drive a five-digit seven-segment display for values, settings, status and errors.
// - Each mode key press cycles views: status, error codes, parameters; the code ignores mode during the name phase and the save message.
// - A newly detected error forces the display to the error code; the code ignores it during the name phase and the save message.
// - With an error active, twenty idle seconds return the display to the error.
// - In parameter view with no value open, shift advances the parameter group.
// - With a value open, shift moves the edit cursor one digit left.
// - While editing, the digit under the cursor blinks.
// - While editing, up and down keys raise or lower the cursor digit.
// - Not editing, arrows step status selections or parameters within the group.
// - OK on a selected parameter opens its present value for editing.
// - A second OK commits the edited value to parameter storage.
// - After a save, show a result message for about one second.
package fpm_pkg;

	localparam int unsigned CLK_HZ         = 125_000_000;
	localparam int unsigned DIGITS         = 5;
	localparam int unsigned NUM_KEYS       = 5;
	localparam int unsigned MSG_TIME_MS    = 1000;
	localparam int unsigned IDLE_TIME_MS   = 20000;
	localparam int unsigned DEB_TIME_MS    = 10;
	localparam int unsigned BLINK_TIME_MS  = 250;
	localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
	localparam int unsigned MSG_CYC        = MSG_TIME_MS * CYC_PER_MS;
	localparam int unsigned IDLE_CYC       = IDLE_TIME_MS * CYC_PER_MS;
	localparam int unsigned DEB_CYC        = DEB_TIME_MS * CYC_PER_MS;
	localparam int unsigned BLINK_CYC      = BLINK_TIME_MS * CYC_PER_MS;

	localparam int unsigned KEY_MODE       = 0;
	localparam int unsigned KEY_SHIFT      = 1;
	localparam int unsigned KEY_UP         = 2;
	localparam int unsigned KEY_DOWN       = 3;
	localparam int unsigned KEY_OK         = 4;

	localparam logic [4:0]  NUM_SEL        = 5'h18;
	localparam logic [3:0]  NUM_GROUPS     = 4'h9;
	localparam logic [7:0]  NUM_PARAMS     = 8'h64;
	localparam logic [3:0]  DIGIT_MAX      = 4'h9;
	localparam logic [2:0]  CUR_MAX        = 3'h4;

	localparam logic [7:0]  GLYPH_BLANK    = 8'h00;

	typedef enum logic [2:0] {
		FPM_ST_NAME,
		FPM_ST_STATUS,
		FPM_ST_ERROR,
		FPM_ST_PARAM,
		FPM_ST_EDIT,
		FPM_ST_MSG
	} fpm_state_t;

	typedef struct packed {
		logic ok;
		logic down;
		logic up;
		logic shift;
		logic mode;
	} fpm_keys_t;

	typedef struct packed {
		logic [3:0]  group;
		logic [7:0]  index;
		logic [19:0] value;
	} fpm_param_t;

	typedef struct packed {
		logic [2:0]  code;
		logic        done;
	} fpm_save_res_t;

endpackage : fpm_pkg
